// ==== logic/pcl_pkg.sv ====
`default_nettype none
package pcl_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int POS_W = 32;
    localparam int NUM_AXES = 12;
    localparam int NUM_HW = 5;
    localparam int NUM_IN = 16;
    localparam int NUM_EV = 4;
    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CFG_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] RISE_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] FALL_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 8'h1C;
    // control register bits
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_ABORT_BIT = 1;
    localparam int CFG_W = 20;
    // status register fields
    localparam int ST_DONE_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_ACTIVE_BIT = 2;
    localparam int ST_ABORT_BIT = 3;
    localparam int ST_ERR_BIT = 4;
    localparam int ST_TOUCH_LSB = 5;
    localparam int ST_ECODE_LSB = 16;
    // interrupt event bits
    localparam int EV_LATCH = 0;
    localparam int EV_DONE = 1;
    localparam int EV_ERR = 2;
    localparam int EV_ABORT = 3;
    // selector limits and modes
    localparam logic [3:0] MAX_AXIS = 4'hB;
    localparam logic [2:0] MAX_HW_AXIS = 3'h4;
    localparam logic [2:0] MAX_MODE = 3'h6;
    localparam logic [2:0] MODE_HSC_SINGLE = 3'h0;
    localparam logic [2:0] MODE_HSC_CONT = 3'h1;
    localparam logic [2:0] MODE_HSC_ARMED = 3'h2;
    localparam logic [2:0] MODE_ENC_SINGLE = 3'h3;
    localparam logic [2:0] MODE_ENC_CONT = 3'h4;
    localparam logic [2:0] MODE_NET_SINGLE = 3'h5;
    localparam logic [2:0] MODE_NET_CONT = 3'h6;
    localparam logic [1:0] TOUCH_MAX = 2'h3;
    // error codes
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_MODE = 16'h0001;
    localparam logic [15:0] ERR_AXIS = 16'h0002;
    localparam logic [15:0] ERR_HW_AXIS = 16'h0003;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // capture configuration, laid out as the config register
    typedef struct packed {
        logic [2:0] hw_axis;
        logic [3:0] axis;
        logic [2:0] mode;
        logic trigger_edge_select;
        logic arm_edge_select;
        logic [3:0] arm_input_select;
        logic [3:0] trigger_input_select;
    } pcl_cfg_t;
endpackage : pcl_pkg
`default_nettype wire

// ==== logic/pcl_position_capture_latch.sv ====
// How it works
// - start rising edge begins capture, samples config
// - trigger selector 0-15 picks one input
// - arming selector used only in mode 2
// - arming edge: false falling, true rising
// - trigger edge: 0 falling, 1 rising
// - modes 0 to 6 select behaviour
// - axis picks counter or latched axis
// - hardware axis 0-4 supplies encoder position
// - done flag on finish, modes 0,3
// - busy and in-control while capture runs
// - failure sets error flag and code
// - modes 2,4 count latches 0 to 3
// - rising setting writes rise result
// - falling setting writes fall result
// - single honours first edge, continuous every
// - mode 2 needs arm edge per trigger
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`default_nettype none
module pcl_position_capture_latch (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [pcl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pcl_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [pcl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [pcl_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // digital inputs, bank one low byte, bank two high byte
    input wire logic [pcl_pkg::NUM_IN-1:0] din,
    // position sources
    input wire logic [pcl_pkg::NUM_AXES*pcl_pkg::POS_W-1:0] hsc_count,
    input wire logic [pcl_pkg::NUM_HW*pcl_pkg::POS_W-1:0] enc_pos,
    // interrupt
    output logic irq
);
    typedef enum logic [0:0] {PCL_IDLE, PCL_RUN} pcl_state_t;

    logic wr_do;
    logic [pcl_pkg::ADDR_W-1:0] aw_addr_ff;
    logic [pcl_pkg::DATA_W-1:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic aw_got_ff, w_got_ff;
    logic start_ff, start_d_ff, abort_cmd_ff;
    logic [pcl_pkg::CFG_W-1:0] cfg_reg_ff;
    pcl_pkg::pcl_cfg_t cfg_ff;
    logic [pcl_pkg::NUM_IN-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, lvl_d_ff;
    logic [pcl_pkg::NUM_IN-1:0] nxt_lvl;
    pcl_state_t state_ff;
    logic done_ff, busy_ff, active_ff, aborted_ff, err_ff, armed_ff;
    logic [15:0] error_code_ff;
    logic [1:0] touched_ff;
    logic signed [pcl_pkg::POS_W-1:0] rise_latched_pos_ff;
    logic signed [pcl_pkg::POS_W-1:0] fall_latched_pos_ff;
    logic [pcl_pkg::NUM_EV-1:0] ev_ff, irq_stat_ff, irq_en_ff;
    logic start_rise, trig_hit, arm_hit, single_mode;
    logic [pcl_pkg::POS_W-1:0] cap_pos;
    logic [15:0] cfg_err;
    pcl_pkg::pcl_cfg_t new_cfg;

    // byte-lane write merge
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // edge of a filtered input
    function automatic logic edge_hit(input logic [15:0] cur,
            input logic [15:0] prev, input logic [3:0] sel,
            input logic rising);
        return rising ? (cur[sel] & ~prev[sel]) : (~cur[sel] & prev[sel]);
    endfunction

    // pick one word out of a flat bus
    function automatic logic [31:0] pick(input logic [383:0] bus,
            input logic [3:0] idx);
        return bus[idx*32 +: 32];
    endfunction

    assign wr_do = aw_got_ff & w_got_ff & ~s_axi_bvalid;

    // write channels in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pcl_pkg::RESP_OKAY;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff <= '0;
            w_strb_ff <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_ff)
                    pcl_pkg::CTRL_OFS, pcl_pkg::CFG_OFS,
                    pcl_pkg::IRQ_CLR_OFS, pcl_pkg::IRQ_EN_OFS: begin
                        s_axi_bresp <= pcl_pkg::RESP_OKAY;
                    end
                    default: s_axi_bresp <= pcl_pkg::RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_ff <= 1'b0;
            abort_cmd_ff <= 1'b0;
            cfg_reg_ff <= '0;
            irq_en_ff <= '0;
        end else begin
            abort_cmd_ff <= 1'b0;
            if (wr_do && aw_addr_ff == pcl_pkg::CTRL_OFS) begin
                start_ff <= w_strb_ff[0] ? w_data_ff[pcl_pkg::CTRL_START_BIT]
                    : start_ff;
                abort_cmd_ff <= w_strb_ff[0]
                    & w_data_ff[pcl_pkg::CTRL_ABORT_BIT];
            end
            if (wr_do && aw_addr_ff == pcl_pkg::CFG_OFS) begin
                cfg_reg_ff <= pcl_pkg::CFG_W'(merge({12'h0, cfg_reg_ff},
                    w_data_ff, w_strb_ff));
            end
            if (wr_do && aw_addr_ff == pcl_pkg::IRQ_EN_OFS) begin
                irq_en_ff <= pcl_pkg::NUM_EV'(merge({28'h0, irq_en_ff},
                    w_data_ff, w_strb_ff));
            end
        end
    end

    // read channel, one outstanding read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= pcl_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= pcl_pkg::RESP_OKAY;
            case (s_axi_araddr)
                pcl_pkg::CTRL_OFS: s_axi_rdata <= {31'h0, start_ff};
                pcl_pkg::CFG_OFS: s_axi_rdata <= {12'h0, cfg_reg_ff};
                pcl_pkg::STAT_OFS: begin
                    s_axi_rdata <= '0;
                    s_axi_rdata[pcl_pkg::ST_DONE_BIT] <= done_ff;
                    s_axi_rdata[pcl_pkg::ST_BUSY_BIT] <= busy_ff;
                    s_axi_rdata[pcl_pkg::ST_ACTIVE_BIT] <= active_ff;
                    s_axi_rdata[pcl_pkg::ST_ABORT_BIT] <= aborted_ff;
                    s_axi_rdata[pcl_pkg::ST_ERR_BIT] <= err_ff;
                    s_axi_rdata[pcl_pkg::ST_TOUCH_LSB +: 2] <= touched_ff;
                    s_axi_rdata[pcl_pkg::ST_ECODE_LSB +: 16] <= error_code_ff;
                end
                pcl_pkg::RISE_OFS: s_axi_rdata <= rise_latched_pos_ff;
                pcl_pkg::FALL_OFS: s_axi_rdata <= fall_latched_pos_ff;
                pcl_pkg::IRQ_STAT_OFS: s_axi_rdata <= {28'h0, irq_stat_ff};
                pcl_pkg::IRQ_EN_OFS: s_axi_rdata <= {28'h0, irq_en_ff};
                pcl_pkg::IRQ_CLR_OFS: s_axi_rdata <= '0;
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= pcl_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // three-stage sync; a level is taken once stages two and three agree
    assign nxt_lvl = (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            lvl_ff <= '0;
            lvl_d_ff <= '0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
            lvl_d_ff <= lvl_ff;
        end
    end

    // edge decode on the sampled selections
    always_comb begin
        start_rise = start_ff & ~start_d_ff;
        trig_hit = edge_hit(lvl_ff, lvl_d_ff, cfg_ff.trigger_input_select,
            cfg_ff.trigger_edge_select);
        arm_hit = edge_hit(lvl_ff, lvl_d_ff, cfg_ff.arm_input_select,
            cfg_ff.arm_edge_select);
        single_mode = cfg_ff.mode == pcl_pkg::MODE_HSC_SINGLE
            || cfg_ff.mode == pcl_pkg::MODE_ENC_SINGLE
            || cfg_ff.mode == pcl_pkg::MODE_NET_SINGLE;
        if (cfg_ff.mode <= pcl_pkg::MODE_HSC_ARMED) begin
            cap_pos = pick(hsc_count, cfg_ff.axis);
        end else begin
            cap_pos = pick({224'h0, enc_pos}, {1'b0, cfg_ff.hw_axis});
        end
    end

    // configuration check at start
    always_comb begin
        new_cfg = pcl_pkg::pcl_cfg_t'(cfg_reg_ff);
        cfg_err = pcl_pkg::ERR_NONE;
        if (new_cfg.mode > pcl_pkg::MAX_MODE) begin
            cfg_err = pcl_pkg::ERR_MODE;
        end else if (new_cfg.mode <= pcl_pkg::MODE_ENC_CONT
                && new_cfg.axis > pcl_pkg::MAX_AXIS) begin
            cfg_err = pcl_pkg::ERR_AXIS;
        end else if (new_cfg.mode >= pcl_pkg::MODE_ENC_SINGLE
                && new_cfg.hw_axis > pcl_pkg::MAX_HW_AXIS) begin
            cfg_err = pcl_pkg::ERR_HW_AXIS;
        end
    end

    // capture sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= PCL_IDLE;
            start_d_ff <= 1'b0;
            cfg_ff <= '0;
            done_ff <= 1'b0;
            busy_ff <= 1'b0;
            active_ff <= 1'b0;
            aborted_ff <= 1'b0;
            err_ff <= 1'b0;
            armed_ff <= 1'b0;
            error_code_ff <= pcl_pkg::ERR_NONE;
            touched_ff <= '0;
            rise_latched_pos_ff <= '0;
            fall_latched_pos_ff <= '0;
            ev_ff <= '0;
        end else begin
            start_d_ff <= start_ff;
            ev_ff <= '0;
            case (state_ff)
                PCL_IDLE: begin
                    if (!start_ff) begin
                        done_ff <= 1'b0;
                        aborted_ff <= 1'b0;
                        err_ff <= 1'b0;
                    end
                    if (start_rise) begin
                        cfg_ff <= new_cfg;
                        done_ff <= 1'b0;
                        aborted_ff <= 1'b0;
                        armed_ff <= 1'b0;
                        touched_ff <= '0;
                        error_code_ff <= cfg_err;
                        if (cfg_err != pcl_pkg::ERR_NONE) begin
                            err_ff <= 1'b1;
                            ev_ff[pcl_pkg::EV_ERR] <= 1'b1;
                        end else begin
                            err_ff <= 1'b0;
                            busy_ff <= 1'b1;
                            active_ff <= 1'b1;
                            state_ff <= PCL_RUN;
                        end
                    end
                end
                PCL_RUN: begin
                    if (abort_cmd_ff || start_rise) begin
                        aborted_ff <= 1'b1;
                        busy_ff <= 1'b0;
                        active_ff <= 1'b0;
                        ev_ff[pcl_pkg::EV_ABORT] <= 1'b1;
                        state_ff <= PCL_IDLE;
                    end else begin
                        if (cfg_ff.mode == pcl_pkg::MODE_HSC_ARMED
                                && arm_hit) begin
                            armed_ff <= 1'b1;
                        end
                        if (trig_hit && (armed_ff
                                || cfg_ff.mode != pcl_pkg::MODE_HSC_ARMED)) begin
                            armed_ff <= 1'b0;
                            ev_ff[pcl_pkg::EV_LATCH] <= 1'b1;
                            if (cfg_ff.trigger_edge_select) begin
                                rise_latched_pos_ff <= cap_pos;
                            end else begin
                                fall_latched_pos_ff <= cap_pos;
                            end
                            // latch count wraps 3 to 0
                            if (cfg_ff.mode == pcl_pkg::MODE_HSC_ARMED
                                    || cfg_ff.mode == pcl_pkg::MODE_ENC_CONT) begin
                                touched_ff <= (touched_ff == pcl_pkg::TOUCH_MAX)
                                    ? 2'h0 : touched_ff + 2'h1;
                            end
                            // single mode ends on first edge
                            if (single_mode) begin
                                busy_ff <= 1'b0;
                                active_ff <= 1'b0;
                                state_ff <= PCL_IDLE;
                                // done in modes 0 and 3
                                if (cfg_ff.mode != pcl_pkg::MODE_NET_SINGLE) begin
                                    done_ff <= 1'b1;
                                    ev_ff[pcl_pkg::EV_DONE] <= 1'b1;
                                end
                            end
                        end
                    end
                end
                default: state_ff <= PCL_IDLE;
            endcase
        end
    end

    // sticky interrupt status, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_ff <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_do && aw_addr_ff == pcl_pkg::IRQ_CLR_OFS && w_strb_ff[0]) begin
                irq_stat_ff <= (irq_stat_ff & ~w_data_ff[pcl_pkg::NUM_EV-1:0])
                    | ev_ff;
            end else begin
                irq_stat_ff <= irq_stat_ff | ev_ff;
            end
            irq <= |(irq_stat_ff & irq_en_ff);
        end
    end
endmodule : pcl_position_capture_latch
`default_nettype wire

// ==== verification/pcl_position_capture_latch_chk.sv ====
`default_nettype none
module pcl_capture_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic [pcl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [pcl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [pcl_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // one clock domain
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    reset_quiet_a: assert property (disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("outputs not idle after reset");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    ro_write_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == pcl_pkg::STAT_OFS
        |-> ##[1:2] s_axi_bvalid && s_axi_bresp == pcl_pkg::RESP_SLVERR)
        else $error("read-only write not refused");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read data late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open early");
    aw_block_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write open early");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr > pcl_pkg::IRQ_EN_OFS
        |=> s_axi_rresp == pcl_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule // pcl_capture_chk

bind pcl_position_capture_latch pcl_capture_chk u_chk (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
);
`default_nettype wire

// ==== verification/pcl_io_model.sv ====
`default_nettype none
module pcl_io_model (
    // levels and offset from the bench
    input wire logic [15:0] lvl,
    input wire logic [15:0] ofs,
    // pins toward the capture unit
    output logic [15:0] din,
    output logic [383:0] hsc_count,
    output logic [159:0] enc_pos
);
    timeunit 1ns;
    timeprecision 1ps;
    // input pins follow the bench levels
    assign din = lvl;
    // kind tag, axis number, offset
    always_comb begin
        for (int n = 0; n < 12; n++)
            hsc_count[n*32+:32] = {8'hA0, 8'(n), ofs};
        for (int n = 0; n < 5; n++)
            enc_pos[n*32+:32] = {8'hE0, 8'(n), ofs};
    end
endmodule // pcl_io_model
`default_nettype wire

// ==== verification/pcl_position_capture_latch_bench.sv ====
`default_nettype none
module pcl_position_capture_latch_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // bench-driven inputs
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [15:0] lvl = 16'h0, ofs = 16'h0;
    // design outputs and answers
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, brsp;
    logic [31:0] s_axi_rdata, rdat;
    logic [15:0] din;
    logic [383:0] hsc_count;
    logic [159:0] enc_pos;
    logic [2:0] md [4] = '{3'h1, 3'h3, 3'h5, 3'h6};
    logic [31:0] bad [3];
    int n_errors = 0;
    int samples_checked = 0;

    always #2.5 aclk = ~aclk;

    pcl_position_capture_latch u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .din, .hsc_count, .enc_pos, .irq
    );
    pcl_io_model u_io (.lvl, .ofs, .din, .hsc_count, .enc_pos);

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask

    // write one word
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        brsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    // read one word
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // read and compare masked bits
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e);
        rd(a);
        chk(rdat & m, e);
    endtask

    // high pulse, both edges seen
    task automatic pulse(input int i);
        lvl[i] <= 1'b1;
        repeat (8) @(posedge aclk);
        lvl[i] <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask

    // configure then raise start
    task automatic start(input logic [31:0] c);
        wr(pcl_pkg::CFG_OFS, c);
        wr(pcl_pkg::CTRL_OFS, 32'h1);
    endtask

    // abort, then drop start
    task automatic stop_cap;
        wr(pcl_pkg::CTRL_OFS, 32'h3);
        wr(pcl_pkg::CTRL_OFS, 32'h0);
    endtask

    function automatic logic [31:0] cfg(input logic [2:0] m,
            input logic [3:0] ax, input logic [2:0] hw, input logic te,
            input logic ae, input logic [3:0] ai, input logic [3:0] ti);
        return 32'(pcl_pkg::pcl_cfg_t'{hw, ax, m, te, ae, ai, ti});
    endfunction

    function automatic logic [31:0] pos(input logic e, input logic [7:0] n,
            input logic [15:0] o);
        return {e ? 8'hE0 : 8'hA0, n, o};
    endfunction

    task automatic stop_test;
        $display("checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // main sequence
    initial begin
        bad = '{cfg(3'h7, 4'h0, 3'h0, 1'b1, 1'b0, 4'h0, 4'h0),
            cfg(3'h0, 4'hC, 3'h0, 1'b1, 1'b0, 4'h0, 4'h0),
            cfg(3'h3, 4'h0, 3'h5, 1'b1, 1'b0, 4'h0, 4'h0)};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(pcl_pkg::STAT_OFS, '1, 32'h0);
        rdc(pcl_pkg::IRQ_EN_OFS, '1, 32'h0);
        rdc(8'h40, '1, 32'h0);
        chk({30'h0, rrsp}, {30'h0, pcl_pkg::RESP_SLVERR});
        wr(pcl_pkg::STAT_OFS, 32'hFF);
        chk({30'h0, brsp}, {30'h0, pcl_pkg::RESP_SLVERR});
        rdc(pcl_pkg::STAT_OFS, '1, 32'h0);
        wr(pcl_pkg::IRQ_EN_OFS, 32'hF);
        // single counter capture on input 3
        ofs <= 16'h1234;
        start(cfg(3'h0, 4'h2, 3'h0, 1'b1, 1'b0, 4'h0, 4'h3));
        rdc(pcl_pkg::STAT_OFS, 32'h1F, 32'h6);
        pulse(3);
        rdc(pcl_pkg::RISE_OFS, '1, pos(1'b0, 8'h2, 16'h1234));
        rdc(pcl_pkg::STAT_OFS, 32'h1F, 32'h1);
        ofs <= 16'h5678;
        pulse(3);
        rdc(pcl_pkg::RISE_OFS, '1, pos(1'b0, 8'h2, 16'h1234));
        rdc(pcl_pkg::IRQ_STAT_OFS, '1, 32'h3);
        chk(32'(irq), 32'h1);
        wr(pcl_pkg::IRQ_CLR_OFS, 32'h3);
        rdc(pcl_pkg::IRQ_STAT_OFS, '1, 32'h0);
        chk(32'(irq), 32'h0);
        stop_cap;
        // continuous encoder capture on input 9
        start(cfg(3'h4, 4'h3, 3'h4, 1'b0, 1'b0, 4'h0, 4'h9));
        for (int k = 1; k <= 5; k++) begin
            ofs <= 16'(k);
            pulse(9);
            rdc(pcl_pkg::FALL_OFS, '1, pos(1'b1, 8'h4, 16'(k)));
        end
        rdc(pcl_pkg::STAT_OFS, '1, 32'h26);
        rdc(pcl_pkg::RISE_OFS, '1, pos(1'b0, 8'h2, 16'h1234));
        // leave continuous mode
        wr(pcl_pkg::CTRL_OFS, 32'h3);
        rdc(pcl_pkg::STAT_OFS, 32'h1F, 32'h8);
        wr(pcl_pkg::CTRL_OFS, 32'h0);
        // armed mode, arm input 5, trigger input 12
        start(cfg(3'h2, 4'h7, 3'h0, 1'b1, 1'b1, 4'h5, 4'hC));
        ofs <= 16'h0AAA;
        pulse(12);
        rdc(pcl_pkg::RISE_OFS, '1, pos(1'b0, 8'h2, 16'h1234));
        pulse(5);
        ofs <= 16'h0BBB;
        pulse(12);
        rdc(pcl_pkg::RISE_OFS, '1, pos(1'b0, 8'h7, 16'h0BBB));
        ofs <= 16'h0CCC;
        pulse(12);
        rdc(pcl_pkg::RISE_OFS, '1, pos(1'b0, 8'h7, 16'h0BBB));
        rdc(pcl_pkg::STAT_OFS, '1, 32'h26);
        stop_cap;
        // other modes, rising edge on input 0
        foreach (md[j]) begin
            start(cfg(md[j], 4'h1, 3'h1, 1'b1, 1'b0, 4'h0, 4'h0));
            ofs <= 16'(j);
            pulse(0);
            rdc(pcl_pkg::RISE_OFS, '1, pos(md[j] > 3'h2, 8'h1, 16'(j)));
            rd(pcl_pkg::STAT_OFS);
            chk(32'(rdat[0]), 32'(md[j] == 3'h3));
            stop_cap;
        end
        // refused setups
        wr(pcl_pkg::IRQ_EN_OFS, 32'h0);
        wr(pcl_pkg::IRQ_CLR_OFS, 32'hF);
        foreach (bad[j]) begin
            start(bad[j]);
            rdc(pcl_pkg::STAT_OFS, 32'hFFFF001F, {16'(j + 1), 16'h0010});
            wr(pcl_pkg::CTRL_OFS, 32'h0);
        end
        chk(32'(irq), 32'h0);
        wr(pcl_pkg::IRQ_EN_OFS, 32'h4);
        rdc(pcl_pkg::IRQ_STAT_OFS, 32'h4, 32'h4);
        chk(32'(irq), 32'h1);
        wr(pcl_pkg::IRQ_CLR_OFS, 32'h4);
        rdc(pcl_pkg::IRQ_STAT_OFS, '1, 32'h0);
        chk(32'(irq), 32'h0);
        stop_test;
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        stop_test;
    end
endmodule // pcl_position_capture_latch_bench
`default_nettype wire
